// [rtl/trig_pkg.sv]
// package: register map, field layout, timing constants and types of the enhanced trigger
package trig_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int N_ANALOG = 16;
    localparam int N_COMPUTED = 6;
    localparam int N_SRC = N_ANALOG + N_COMPUTED;
    localparam int N_PROBE = 16;
    localparam int PROBE_PORT_BITS = 8;
    localparam int LEVEL_W = 16;
    localparam int CNT_W = 27;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned TICK_NS = 100;
    localparam longint unsigned TICK_CYCLES = TICK_NS * CLK_HZ / 1_000_000_000;
    localparam longint unsigned PW_MIN_NS = 100;
    localparam longint unsigned PW_MAX_S = 10;
    localparam longint unsigned PW_RESET_NS = 100;
    localparam logic [CNT_W-1:0] PW_MIN_TICKS = CNT_W'(PW_MIN_NS / TICK_NS);
    localparam logic [CNT_W-1:0] PW_MAX_TICKS =
        CNT_W'(PW_MAX_S * 1_000_000_000 / TICK_NS);
    localparam logic [CNT_W-1:0] PW_RESET_TICKS = CNT_W'(PW_RESET_NS / TICK_NS);

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EDGE_ANALOG = 8'h08;
    localparam logic [7:0] ADDR_EDGE_COMPUTED = 8'h0C;
    localparam logic [7:0] ADDR_EDGE_PROBE = 8'h10;
    localparam logic [7:0] ADDR_PAT_ANALOG = 8'h14;
    localparam logic [7:0] ADDR_PAT_PROBE = 8'h18;
    localparam logic [7:0] ADDR_WIDTH = 8'h1C;
    localparam logic [7:0] ADDR_COUNT = 8'h20;
    localparam logic [7:0] ADDR_LEVEL_BASE = 8'h40;

    // ctrl field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PTYPE_LSB = 2;
    localparam int CTRL_HYST_LSB = 4;
    localparam int CTRL_PROBE_EN_A = 8;
    localparam int CTRL_PROBE_EN_B = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status field positions
    localparam int STAT_TRIG = 0;
    localparam int STAT_QUAL = 1;
    localparam int STAT_CNT_LSB = 16;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_OR = 2'b01,
        MODE_PULSE = 2'b10,
        MODE_SPARE = 2'b11
    } trig_mode_t;

    typedef enum logic [1:0] {
        PT_LONGER = 2'b00,
        PT_SHORTER = 2'b01,
        PT_TIMEOUT = 2'b10,
        PT_SPARE = 2'b11
    } pulse_type_t;

    // two-bit per-source selector: edge (rise/fall) or pattern (high/low)
    localparam logic [1:0] SEL_IGNORE = 2'h0;
    localparam logic [1:0] SEL_RISE_HIGH = 2'h1;
    localparam logic [1:0] SEL_FALL_LOW = 2'h2;

    typedef struct packed {
        logic probe_en_b;
        logic probe_en_a;
        logic [1:0] spare;
        logic [1:0] hyst;
        pulse_type_t ptype;
        trig_mode_t mode;
    } ctrl_t;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : trig_pkg

// [rtl/edge_pulse_trigger.sv]
// top: or-of-edges and pulse-width trigger with an axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module edge_pulse_trigger
    import trig_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // comparator side (asynchronous)
    input wire logic [N_SRC-1:0] src_above_i,
    input wire logic [N_SRC-1:0] src_below_i,
    input wire logic [N_PROBE-1:0] probe_i,
    output logic [N_SRC-1:0][LEVEL_W-1:0] level_o,
    output logic [1:0] hyst_sel_o,
    // trigger event
    output logic trig_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[8*b +: 8] = new_v[8*b +: 8];
        end
        return res;
    endfunction : merge_strb

    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic prev);
        return (sel == SEL_RISE_HIGH && now && !prev) ||
               (sel == SEL_FALL_LOW && !now && prev);
    endfunction : edge_hit

    function automatic logic pat_ok(input logic [1:0] sel, input logic lvl);
        return (sel == SEL_RISE_HIGH) ? lvl : (sel == SEL_FALL_LOW) ? !lvl : 1'b1;
    endfunction : pat_ok

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    ctrl_t ctrl_reg;
    logic [2*N_ANALOG-1:0] edge_analog_reg;
    logic [2*N_COMPUTED-1:0] edge_comp_reg;
    logic [2*N_PROBE-1:0] edge_probe_reg;
    logic [2*N_ANALOG-1:0] pat_analog_reg;
    logic [2*N_PROBE-1:0] pat_probe_reg;
    logic [CNT_W-1:0] width_reg;
    logic [LEVEL_W-1:0] level_reg [N_SRC];
    logic trig_seen_reg;
    logic [15:0] trig_cnt_reg;

    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] wr_val;

    assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held_reg && !s_axi_bvalid_o;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_i;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    always_comb
    begin
        wr_hit = (awaddr_reg[7:2] <= ADDR_WIDTH[7:2]) && (awaddr_reg[7:2] != ADDR_COUNT[7:2]);
        if (awaddr_reg >= ADDR_LEVEL_BASE &&
            awaddr_reg[7:2] < ADDR_LEVEL_BASE[7:2] + 6'(N_SRC))
            wr_hit = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= ctrl_t'(CTRL_RESET[9:0]);
            edge_analog_reg <= '0;
            edge_comp_reg <= '0;
            edge_probe_reg <= '0;
            pat_analog_reg <= '0;
            pat_probe_reg <= '0;
            width_reg <= PW_RESET_TICKS;
            for (int i = 0; i < N_SRC; i++)
                level_reg[i] <= '0;
        end
        else if (wr_fire)
        begin
            unique case (awaddr_reg)
                ADDR_CTRL:
                begin
                    ctrl_reg <= ctrl_t'(wr_val[9:0]);
                    // spare band code refused: the comparators keep the last band
                    if (wr_val[CTRL_HYST_LSB +: 2] == 2'h3)
                        ctrl_reg.hyst <= ctrl_reg.hyst;
                end
                ADDR_EDGE_ANALOG: edge_analog_reg <= wr_val;
                ADDR_EDGE_COMPUTED: edge_comp_reg <= wr_val[2*N_COMPUTED-1:0];
                ADDR_EDGE_PROBE: edge_probe_reg <= wr_val;
                ADDR_PAT_ANALOG: pat_analog_reg <= wr_val;
                ADDR_PAT_PROBE: pat_probe_reg <= wr_val;
                ADDR_WIDTH:
                begin
                    // zero is the reset command; out-of-range values clamp
                    if (wr_val[31:0] == 32'h0000_0000)
                        width_reg <= PW_RESET_TICKS;
                    else if (wr_val[31:CNT_W] != '0 || wr_val[CNT_W-1:0] > PW_MAX_TICKS)
                        width_reg <= PW_MAX_TICKS;
                    else
                        width_reg <= wr_val[CNT_W-1:0];
                end
                default:
                begin
                    for (int i = 0; i < N_SRC; i++)
                    begin
                        if (awaddr_reg[7:2] == ADDR_LEVEL_BASE[7:2] + 6'(i))
                            level_reg[i] <= wr_val[LEVEL_W-1:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // comparator inputs: synchronise and apply hysteresis
    // ------------------------------------------------------------------
    logic [N_SRC-1:0] above_s1_reg, above_s2_reg, below_s1_reg, below_s2_reg;
    logic [N_PROBE-1:0] probe_s1_reg, probe_s2_reg, probe_d_reg;
    logic [N_SRC-1:0] lvl_reg, lvl_d_reg;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            above_s1_reg <= '0;
            above_s2_reg <= '0;
            below_s1_reg <= '0;
            below_s2_reg <= '0;
            probe_s1_reg <= '0;
            probe_s2_reg <= '0;
        end
        else
        begin
            above_s1_reg <= src_above_i;
            above_s2_reg <= above_s1_reg;
            below_s1_reg <= src_below_i;
            below_s2_reg <= below_s1_reg;
            probe_s1_reg <= probe_i;
            probe_s2_reg <= probe_s1_reg;
        end
    end

    // a level only flips once the signal leaves the band; inside it, it holds
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lvl_reg <= '0;
            lvl_d_reg <= '0;
            probe_d_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < N_SRC; i++)
            begin
                if (above_s2_reg[i])
                    lvl_reg[i] <= 1'b1;
                else if (below_s2_reg[i])
                    lvl_reg[i] <= 1'b0;
            end
            lvl_d_reg <= lvl_reg;
            probe_d_reg <= probe_s2_reg;
        end
    end

    assign hyst_sel_o = ctrl_reg.hyst;

    always_comb
    begin
        for (int i = 0; i < N_SRC; i++)
            level_o[i] = level_reg[i];
    end

    // ------------------------------------------------------------------
    // edge OR and qualifier
    // ------------------------------------------------------------------
    logic or_hit;
    logic qual;
    logic [1:0] probe_en;

    assign probe_en = {ctrl_reg.probe_en_b, ctrl_reg.probe_en_a};

    always_comb
    begin
        or_hit = 1'b0;
        for (int i = 0; i < N_ANALOG; i++)
            or_hit |= edge_hit(edge_analog_reg[2*i +: 2], lvl_reg[i], lvl_d_reg[i]);
        for (int i = 0; i < N_COMPUTED; i++)
            or_hit |= edge_hit(edge_comp_reg[2*i +: 2], lvl_reg[N_ANALOG+i],
                               lvl_d_reg[N_ANALOG+i]);
        for (int i = 0; i < N_PROBE; i++)
            or_hit |= probe_en[i/PROBE_PORT_BITS] &&
                      edge_hit(edge_probe_reg[2*i +: 2], probe_s2_reg[i], probe_d_reg[i]);
    end

    always_comb
    begin
        qual = 1'b1;
        for (int i = 0; i < N_ANALOG; i++)
            qual &= pat_ok(pat_analog_reg[2*i +: 2], lvl_reg[i]);
        for (int i = 0; i < N_PROBE; i++)
            qual &= !probe_en[i/PROBE_PORT_BITS] ||
                    pat_ok(pat_probe_reg[2*i +: 2], probe_s2_reg[i]);
    end

    // ------------------------------------------------------------------
    // 100 ns tick and width counter
    // ------------------------------------------------------------------
    logic [7:0] div_reg;
    logic tick;
    logic qual_d_reg;
    logic timeout_done_reg;
    logic [CNT_W-1:0] cnt_reg;

    assign tick = (div_reg == 8'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            div_reg <= 8'h00;
        else if (tick)
            div_reg <= 8'h00;
        else
            div_reg <= div_reg + 8'h01;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            qual_d_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            qual_d_reg <= qual;
            if (qual && !qual_d_reg)
                cnt_reg <= '0;
            else if (qual && tick && cnt_reg != PW_MAX_TICKS)
                cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // trigger decision
    // ------------------------------------------------------------------
    logic fire;
    logic qual_fell;
    logic reached;

    assign qual_fell = qual_d_reg && !qual;
    // short input pulses below one tick are measured but not guaranteed
    assign reached = qual_d_reg && (cnt_reg >= width_reg);

    always_comb
    begin
        fire = 1'b0;
        unique case (ctrl_reg.mode)
            MODE_OR: fire = or_hit;
            MODE_PULSE:
            begin
                unique case (ctrl_reg.ptype)
                    PT_LONGER: fire = qual_fell && reached;
                    PT_SHORTER: fire = qual_fell && !reached;
                    PT_TIMEOUT: fire = qual && reached && !timeout_done_reg;
                    default: fire = 1'b0;
                endcase
            end
            default: fire = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timeout_done_reg <= 1'b0;
        else if (!qual)
            timeout_done_reg <= 1'b0;
        else if (fire && ctrl_reg.mode == MODE_PULSE && ctrl_reg.ptype == PT_TIMEOUT)
            timeout_done_reg <= 1'b1;
    end

    // status: the sticky flag is write-one-to-clear and a new trigger wins
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            trig_o <= 1'b0;
            trig_seen_reg <= 1'b0;
            trig_cnt_reg <= 16'h0000;
        end
        else
        begin
            trig_o <= fire;
            if (fire)
            begin
                trig_seen_reg <= 1'b1;
                trig_cnt_reg <= trig_cnt_reg + 16'h0001;
            end
            else if (wr_fire && awaddr_reg == ADDR_STATUS && wr_val[STAT_TRIG])
                trig_seen_reg <= 1'b0;
        end
    end

    // a process, not an assign: rd_word reads the registers, not only its argument
    always_comb
    begin
        wr_val = merge_strb(32'h0000_0000, wdata_reg, wstrb_reg) |
                 (rd_word(awaddr_reg) & ~{{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                                          {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}});
    end

    // ------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            ADDR_CTRL: v = 32'(ctrl_reg);
            ADDR_STATUS: v = {trig_cnt_reg, 14'h0000, qual, trig_seen_reg};
            ADDR_EDGE_ANALOG: v = edge_analog_reg;
            ADDR_EDGE_COMPUTED: v = 32'(edge_comp_reg);
            ADDR_EDGE_PROBE: v = edge_probe_reg;
            ADDR_PAT_ANALOG: v = pat_analog_reg;
            ADDR_PAT_PROBE: v = pat_probe_reg;
            ADDR_WIDTH: v = 32'(width_reg);
            ADDR_COUNT: v = 32'(cnt_reg);
            default:
            begin
                for (int i = 0; i < N_SRC; i++)
                begin
                    if (a[7:2] == ADDR_LEVEL_BASE[7:2] + 6'(i))
                        v = 32'(level_reg[i]);
                end
            end
        endcase
        return v;
    endfunction : rd_word

    function automatic logic rd_ok(input logic [7:0] a);
        return (a[7:2] <= ADDR_COUNT[7:2]) ||
               (a >= ADDR_LEVEL_BASE && a[7:2] < ADDR_LEVEL_BASE[7:2] + 6'(N_SRC));
    endfunction : rd_ok

    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= AXI_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_ok(s_axi_araddr_i) ? rd_word(s_axi_araddr_i) : 32'h0000_0000;
            s_axi_rresp_o <= rd_ok(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end

endmodule : edge_pulse_trigger

// [bench/comparator_model.sv]
// partner: level comparators turning a wanted source state into band flags
`timescale 1ns/1ps
module comparator_model
    import trig_pkg::*;
(
    // wanted state per source, from the bench
    input wire logic [N_SRC-1:0] want_i,
    // band-edge flags to the trigger
    output logic [N_SRC-1:0] above_o,
    output logic [N_SRC-1:0] below_o
);
    // signal sits well clear of the band, so exactly one flag is high at a time
    assign above_o = want_i;
    assign below_o = ~want_i;
endmodule : comparator_model

// [bench/edge_pulse_trigger_monitor.sv]
// checker: port-level properties of the edge and pulse trigger
`timescale 1ns/1ps
module edge_pulse_trigger_monitor
    import trig_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // bus handshakes
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // trigger side
    input wire logic [N_SRC-1:0][LEVEL_W-1:0] level_o,
    input wire logic [1:0] hyst_sel_o,
    input wire logic trig_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    property p_trig_pulse; trig_o |=> !trig_o; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
    property p_hyst_legal; hyst_sel_o != 2'h3; endproperty
    a_hyst_legal: assert property (p_hyst_legal) else $error("spare band selected");
    property p_hyst_cause; $changed(hyst_sel_o) |-> $rose(s_axi_bvalid_o); endproperty
    a_hyst_cause: assert property (p_hyst_cause) else $error("band moved without a write");
    property p_level_cause; $changed(level_o) |-> $rose(s_axi_bvalid_o); endproperty
    a_level_cause: assert property (p_level_cause) else $error("level moved without a write");
    property p_rd_answer; s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
    property p_rd_stand; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data dropped early");
    property p_wr_stand; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
    a_wr_stand: assert property (p_wr_stand) else $error("write response dropped early");
    property p_ar_refuse; s_axi_arready_o == !s_axi_rvalid_o; endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read address ready wrong");
    property p_w_refuse; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken while response pending");
endmodule : edge_pulse_trigger_monitor

bind edge_pulse_trigger edge_pulse_trigger_monitor mon_u (.clk_sys_i, .resetn_i, .s_axi_awready_o,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .level_o, .hyst_sel_o,
    .trig_o);

// [bench/edge_or_and_pulse_width_trigger_tb_top.sv]
// bench: register and trigger scenarios for the edge and pulse trigger
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module edge_or_and_pulse_width_trigger_tb_top;
    import trig_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [N_SRC-1:0] want = '0;
    logic [N_PROBE-1:0] probe = '0;
    logic [1:0] rsp;
    wire logic awready, wready, bvalid, arready, rvalid, trig;
    wire logic [1:0] bresp, rresp, hyst;
    wire logic [31:0] rdata;
    wire logic [N_SRC-1:0] above, below;
    wire logic [N_SRC-1:0][LEVEL_W-1:0] level;
    int failures = 0, checks = 0, fires = 0, cycles = 0, f0;
    int exp_t [3][2] = '{'{1, 0}, '{0, 1}, '{1, 0}};
    int lens [2] = '{120, 30};

    edge_pulse_trigger dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .src_above_i(above),
        .src_below_i(below), .probe_i(probe), .level_o(level), .hyst_sel_o(hyst), .trig_o(trig));
    comparator_model cmp_u (.want_i(want), .above_o(above), .below_o(below));

    always #2.5 clk_sys_i = ~clk_sys_i;
    // hang guard: the whole sequence needs well under 10000 cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (trig === 1'b1) fires++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge clk_sys_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk_sys_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk_sys_i);
            ta = arvalid & arready;
            tr = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge clk_sys_i);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
        `CHK(rd, e)
        `CHK(rsp, er)
    endtask : rdc

    // high for n cycles then a long gap, both above the minimum pulse and gap
    task automatic pulse(input int i, input int n);
        @(posedge clk_sys_i);
        if (i < N_SRC) want[i] <= 1'b1; else probe[i - N_SRC] <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        if (i < N_SRC) want[i] <= 1'b0; else probe[i - N_SRC] <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
    endtask : pulse

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rdc(ADDR_CTRL, CTRL_RESET, AXI_OKAY);
        rdc(ADDR_WIDTH, 32'(PW_RESET_TICKS), AXI_OKAY);
        rdc(8'h3C, 32'h0, AXI_SLVERR);
        wr(ADDR_COUNT, 32'h5);
        `CHK(rsp, AXI_SLVERR)
        wr(ADDR_WIDTH, 32'h0);
        rdc(ADDR_WIDTH, 32'h1, AXI_OKAY);
        wr(ADDR_WIDTH, 32'h05F5_E101);
        rdc(ADDR_WIDTH, 32'(PW_MAX_TICKS), AXI_OKAY);
        wr(ADDR_LEVEL_BASE + 8'h0C, 32'h0000_ABCD);
        `CHK(level[3], 16'hABCD)
        wr(ADDR_CTRL, 32'h0000_0221);
        `CHK(hyst, 2'h2)
        wr(ADDR_CTRL, 32'h0000_0231);
        `CHK(hyst, 2'h2)
        // analog ch0 rise, computed ch1 fall, probe bit 9 fall; ch1 and bit 8 ignored
        wr(ADDR_EDGE_ANALOG, 32'h1);
        wr(ADDR_EDGE_COMPUTED, 32'h8);
        wr(ADDR_EDGE_PROBE, 32'h0008_0000);
        f0 = fires;
        pulse(0, 30);
        pulse(N_ANALOG + 1, 30);
        pulse(N_SRC + 9, 30);
        pulse(1, 30);
        pulse(N_SRC + 8, 30);
        `CHK(fires - f0, 3)
        rdc(ADDR_STATUS, 32'h0003_0003, AXI_OKAY);
        wr(ADDR_STATUS, 32'h1);
        rdc(ADDR_STATUS, 32'h0003_0002, AXI_OKAY);
        wr(ADDR_CTRL, 32'h1);
        f0 = fires;
        pulse(N_SRC + 9, 30);
        `CHK(fires - f0, 0)
        // qualifier ch1 high; probe bit 0 high counts only while port A is enabled
        wr(ADDR_EDGE_ANALOG, 32'h0);
        wr(ADDR_PAT_ANALOG, 32'h4);
        wr(ADDR_PAT_PROBE, 32'h1);
        wr(ADDR_WIDTH, 32'h3);
        for (int pt = 0; pt < 3; pt++)
            for (int k = 0; k < 2; k++)
            begin
                wr(ADDR_CTRL, 32'h2 | (pt << 2));
                f0 = fires;
                pulse(1, lens[k]);
                `CHK(fires - f0, exp_t[pt][k])
            end
        wr(ADDR_CTRL, 32'h0000_0106);
        f0 = fires;
        pulse(1, 30);
        `CHK(fires - f0, 0)
        tally_and_finish();
    end
endmodule : edge_or_and_pulse_width_trigger_tb_top
